/* pkg/glr_pkg.sv */
// Purpose: Shared constants and carrier types for the gauge log, alarm and profile register bank
// Assumes: 16-bit registers addressed by 8-bit command codes
// Notes: Reset values stand for the power-up load from the built-in store
package glr_pkg;
  // Command codes
  localparam logic [7:0] CMD_CHIP_VERSION = 8'h11;
  localparam logic [7:0] CMD_PROFILE_SEL = 8'h12;
  localparam logic [7:0] CMD_LOW_CHARGE_ALM = 8'h13;
  localparam logic [7:0] CMD_LOW_VOLT_ALM = 8'h14;
  localparam logic [7:0] CMD_CYCLE_TALLY = 8'h17;
  localparam logic [7:0] CMD_ALARM_STATE = 8'h19;
  localparam logic [7:0] CMD_PROFILE_ID = 8'h1A;
  localparam logic [7:0] CMD_HIGH_VOLT_ALM = 8'h1F;
  localparam logic [7:0] CMD_LOW_TEMP_ALM = 8'h20;
  localparam logic [7:0] CMD_HIGH_TEMP_ALM = 8'h21;
  localparam logic [7:0] CMD_RUNTIME_LO = 8'h24;
  localparam logic [7:0] CMD_RUNTIME_HI = 8'h25;
  localparam logic [7:0] CMD_TEMP_INT_LO = 8'h26;
  localparam logic [7:0] CMD_TEMP_INT_HI = 8'h27;
  localparam logic [7:0] CMD_CHG_INT_LO = 8'h28;
  localparam logic [7:0] CMD_CHG_INT_HI = 8'h29;
  localparam logic [7:0] CMD_PEAK_VOLT = 8'h2A;
  localparam logic [7:0] CMD_TROUGH_VOLT = 8'h2B;
  localparam logic [7:0] CMD_PEAK_TEMP = 8'h2C;
  localparam logic [7:0] CMD_TROUGH_TEMP = 8'h2D;
  localparam logic [7:0] CMD_OWNER_LO = 8'h36;
  localparam logic [7:0] CMD_OWNER_HI = 8'h37;
  localparam logic [7:0] CMD_CRC_LO = 8'h38;
  localparam logic [7:0] CMD_CRC_HI = 8'h39;
  // Reset values and ranges
  localparam logic [15:0] ZERO16 = 16'h0000;
  localparam logic [15:0] VOLT_MIN = 16'h09C4;
  localparam logic [15:0] VOLT_MAX = 16'h1388;
  localparam logic [15:0] TEMP_MIN = 16'h0980;
  localparam logic [15:0] TEMP_MAX = 16'h0DCC;
  localparam logic [15:0] CHARGE_MAX = 16'h0064;
  localparam logic [15:0] ALARM_STATE_RST = 16'h00C0;
  localparam logic [15:0] RUNTIME_HI_MASK = 16'h00FF;
  localparam logic [15:0] PROFILE_LAST = 16'h0004;
  // Alarm flag positions in the status word
  localparam int ALM_HIGH_VOLT = 15;
  localparam int ALM_LOW_VOLT = 11;
  localparam int ALM_HIGH_TEMP = 12;
  localparam int ALM_LOW_TEMP = 8;
  localparam int ALM_LOW_CHARGE = 9;
  // Measurement sample carried into the bank
  typedef struct packed {
    logic valid;
    logic [15:0] volt_mv;
    logic [15:0] temp_dk;
    logic [15:0] charge_pct;
  } glr_sample_t;
  // Host access request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] cmd;
    logic [15:0] wdata;
  } glr_req_t;
endpackage

/* src/glr_regs.sv */
// Purpose: Log, alarm threshold, status and profile register bank of a battery gauge
// Assumes: Host link delivers decoded command-code accesses one cycle wide
// Notes: Alarm levels and owner tag load from the built-in store on leaving reset
// Behaviour
// - Peak voltage record is read/write, millivolts, starts at zero.
// - Trough voltage record starts at 5 V.
// - Peak temperature record in 0.1 K, starts at minus 30 degrees.
// - Trough temperature record starts at plus 80 degrees.
// - High voltage alarm level zero disables, else millivolt threshold.
// - Low voltage alarm level zero disables, else millivolt threshold.
// - High temperature alarm level zero disables, else 0.1 K threshold.
// - Low temperature alarm level zero disables, else 0.1 K threshold.
// - Low charge alarm level zero disables, 1 to 100 percent threshold.
// - Battery alarm state word is read/write and resets to 0x00C0.
// - Five profiles, selected by codes zero through four.
// - Every profile select write starts a charge initialization.
// - A read-only register reports installed profile identity.
// - Programmable levels and owner tag load from built-in store.
`timescale 1ns/100ps
module glr_regs
  import glr_pkg::*;
#(
  parameter logic [15:0] CHIP_VERSION = 16'h0A5A, // Arbitrary value
  parameter logic [15:0] PROFILE_ID = 16'h0B01 // Arbitrary value
) (
  input wire logic CORE_CLK, // Core clock
  input wire logic RST, // Synchronous reset
  input wire logic CE, // Clock enable, freezes state when low
  input wire glr_req_t REQ, // Host access
  input wire glr_sample_t SAMPLE, // New measurement
  input wire logic [15:0] STORE_ALM_HV, // Built-in store: high voltage level
  input wire logic [15:0] STORE_ALM_LV, // Built-in store: low voltage level
  input wire logic [15:0] STORE_ALM_HT, // Built-in store: high temp level
  input wire logic [15:0] STORE_ALM_LT, // Built-in store: low temp level
  input wire logic [15:0] STORE_ALM_LC, // Built-in store: low charge level
  input wire logic [31:0] STORE_OWNER, // Built-in store: owner tag
  input wire logic [31:0] CRC_RESULT, // Checksum result
  input wire logic CYCLE_TICK, // One charge cycle done
  output logic [15:0] RDATA, // Read data
  output logic RVALID, // Read data valid
  output logic [2:0] PROFILE, // Active profile
  output logic INIT_START, // Charge initialization pulse
  output logic [15:0] ALARM_STATE // Status word
);
  logic [15:0] alm_hv_reg, alm_lv_reg, alm_ht_reg, alm_lt_reg, alm_lc_reg;
  logic [15:0] peak_v_reg, trough_v_reg, peak_t_reg, trough_t_reg;
  logic [15:0] state_reg, state_next, cycles_reg;
  logic [31:0] runtime_reg, temp_int_reg, chg_int_reg, owner_reg;
  logic [2:0] prof_reg;
  logic [15:0] rd_next;
  logic wr_ok, strap_pend_reg;
  logic [4:0] hit;
  // Hit bits in order: high volt, low volt, high temp, low temp, low charge
  // They are combinational, so a flag lands in the same edge as its sample

  assign wr_ok = CE && REQ.wr;

  // Thresholds; store values caught right after reset release
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      strap_pend_reg <= 1'b1;
      alm_hv_reg <= ZERO16;
      alm_lv_reg <= ZERO16;
      alm_ht_reg <= ZERO16;
      alm_lt_reg <= ZERO16;
      alm_lc_reg <= ZERO16;
      owner_reg <= {ZERO16, ZERO16};
    end else if (CE) begin
      if (strap_pend_reg) begin
        strap_pend_reg <= 1'b0;
        alm_hv_reg <= STORE_ALM_HV;
        alm_lv_reg <= STORE_ALM_LV;
        alm_ht_reg <= STORE_ALM_HT;
        alm_lt_reg <= STORE_ALM_LT;
        alm_lc_reg <= STORE_ALM_LC;
        owner_reg <= STORE_OWNER;
      end else if (REQ.wr) begin
        // Levels are stored as written; range limits are the host's business
        if (REQ.cmd == CMD_HIGH_VOLT_ALM) begin
          alm_hv_reg <= REQ.wdata;
        end else if (REQ.cmd == CMD_LOW_VOLT_ALM) begin
          alm_lv_reg <= REQ.wdata;
        end else if (REQ.cmd == CMD_HIGH_TEMP_ALM) begin
          alm_ht_reg <= REQ.wdata;
        end else if (REQ.cmd == CMD_LOW_TEMP_ALM) begin
          alm_lt_reg <= REQ.wdata;
        end else if (REQ.cmd == CMD_LOW_CHARGE_ALM) begin
          alm_lc_reg <= REQ.wdata;
        end
      end
    end
  end

  // Alarm compares; a zero level disables its alarm
  always_comb begin
    hit = '0;
    if (SAMPLE.valid) begin
      hit[0] = (alm_hv_reg != ZERO16) && (SAMPLE.volt_mv >= alm_hv_reg);
      hit[1] = (alm_lv_reg != ZERO16) && (SAMPLE.volt_mv <= alm_lv_reg);
      hit[2] = (alm_ht_reg != ZERO16) && (SAMPLE.temp_dk >= alm_ht_reg);
      hit[3] = (alm_lt_reg != ZERO16) && (SAMPLE.temp_dk <= alm_lt_reg);
      hit[4] = (alm_lc_reg != ZERO16) && (SAMPLE.charge_pct <= alm_lc_reg);
    end
  end

  // Status word: host write replaces it, but a new alarm set wins
  always_comb begin
    state_next = state_reg;
    if (REQ.wr && REQ.cmd == CMD_ALARM_STATE) state_next = REQ.wdata;
    // Sets come last so a clear by the host never hides a fresh alarm
    if (hit[0]) begin
      state_next[ALM_HIGH_VOLT] = 1'b1;
    end
    if (hit[1]) begin
      state_next[ALM_LOW_VOLT] = 1'b1;
    end
    if (hit[2]) begin
      state_next[ALM_HIGH_TEMP] = 1'b1;
    end
    if (hit[3]) begin
      state_next[ALM_LOW_TEMP] = 1'b1;
    end
    if (hit[4]) begin
      state_next[ALM_LOW_CHARGE] = 1'b1;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) state_reg <= ALARM_STATE_RST;
    else if (CE) state_reg <= state_next;
  end

  // History extremes; a sample past the record beats a host write in the same cycle
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      peak_v_reg <= ZERO16;
      trough_v_reg <= VOLT_MAX;
      peak_t_reg <= TEMP_MIN;
      trough_t_reg <= TEMP_MAX;
    end else if (CE) begin
      // A host write that loses here is simply dropped, the record stays truthful
      if (SAMPLE.valid && SAMPLE.volt_mv > peak_v_reg) begin
        peak_v_reg <= SAMPLE.volt_mv;
      end else if (REQ.wr && REQ.cmd == CMD_PEAK_VOLT) begin
        peak_v_reg <= REQ.wdata;
      end
      if (SAMPLE.valid && SAMPLE.volt_mv < trough_v_reg) begin
        trough_v_reg <= SAMPLE.volt_mv;
      end else if (REQ.wr && REQ.cmd == CMD_TROUGH_VOLT) begin
        trough_v_reg <= REQ.wdata;
      end
      if (SAMPLE.valid && SAMPLE.temp_dk > peak_t_reg) begin
        peak_t_reg <= SAMPLE.temp_dk;
      end else if (REQ.wr && REQ.cmd == CMD_PEAK_TEMP) begin
        peak_t_reg <= REQ.wdata;
      end
      if (SAMPLE.valid && SAMPLE.temp_dk < trough_t_reg) begin
        trough_t_reg <= SAMPLE.temp_dk;
      end else if (REQ.wr && REQ.cmd == CMD_TROUGH_TEMP) begin
        trough_t_reg <= REQ.wdata;
      end
    end
  end

  // Log accumulators; runtime and integrals written by the host a half at a time, tally counts ticks
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      cycles_reg <= ZERO16;
      runtime_reg <= {ZERO16, ZERO16};
      temp_int_reg <= {ZERO16, ZERO16};
      chg_int_reg <= {ZERO16, ZERO16};
    end else if (CE) begin
      // Tally wraps silently; a 16-bit count outlives any cell
      if (CYCLE_TICK) begin
        cycles_reg <= cycles_reg + 16'h0001;
      end
      if (wr_ok && REQ.cmd == CMD_RUNTIME_LO) begin
        runtime_reg[15:0] <= REQ.wdata;
      end
      // Runtime is 24 bits wide, so the top byte of the high half reads zero
      if (wr_ok && REQ.cmd == CMD_RUNTIME_HI) begin
        runtime_reg[31:16] <= REQ.wdata & RUNTIME_HI_MASK;
      end
      if (wr_ok && REQ.cmd == CMD_TEMP_INT_LO) begin
        temp_int_reg[15:0] <= REQ.wdata;
      end
      if (wr_ok && REQ.cmd == CMD_TEMP_INT_HI) begin
        temp_int_reg[31:16] <= REQ.wdata;
      end
      if (wr_ok && REQ.cmd == CMD_CHG_INT_LO) begin
        chg_int_reg[15:0] <= REQ.wdata;
      end
      if (wr_ok && REQ.cmd == CMD_CHG_INT_HI) begin
        chg_int_reg[31:16] <= REQ.wdata;
      end
    end
  end

  // Profile select; codes past the last profile keep the profile but still pulse the start
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      prof_reg <= '0;
      INIT_START <= 1'b0;
    end else if (CE) begin
      INIT_START <= wr_ok && REQ.cmd == CMD_PROFILE_SEL;
      if (wr_ok && REQ.cmd == CMD_PROFILE_SEL && REQ.wdata <= PROFILE_LAST) prof_reg <= REQ.wdata[2:0];
    end
  end

  // Read mux; unmapped codes read zero since they have no function
  always_comb begin
    rd_next = ZERO16;
    if (REQ.cmd == CMD_CHIP_VERSION) rd_next = CHIP_VERSION;
    else if (REQ.cmd == CMD_PROFILE_SEL) rd_next = {13'h0000, prof_reg};
    else if (REQ.cmd == CMD_LOW_CHARGE_ALM) rd_next = alm_lc_reg;
    else if (REQ.cmd == CMD_LOW_VOLT_ALM) rd_next = alm_lv_reg;
    else if (REQ.cmd == CMD_CYCLE_TALLY) rd_next = cycles_reg;
    else if (REQ.cmd == CMD_ALARM_STATE) rd_next = state_reg;
    else if (REQ.cmd == CMD_PROFILE_ID) rd_next = PROFILE_ID;
    else if (REQ.cmd == CMD_HIGH_VOLT_ALM) rd_next = alm_hv_reg;
    else if (REQ.cmd == CMD_LOW_TEMP_ALM) rd_next = alm_lt_reg;
    else if (REQ.cmd == CMD_HIGH_TEMP_ALM) rd_next = alm_ht_reg;
    else if (REQ.cmd == CMD_RUNTIME_LO) rd_next = runtime_reg[15:0];
    else if (REQ.cmd == CMD_RUNTIME_HI) rd_next = runtime_reg[31:16];
    else if (REQ.cmd == CMD_TEMP_INT_LO) rd_next = temp_int_reg[15:0];
    else if (REQ.cmd == CMD_TEMP_INT_HI) rd_next = temp_int_reg[31:16];
    else if (REQ.cmd == CMD_CHG_INT_LO) rd_next = chg_int_reg[15:0];
    else if (REQ.cmd == CMD_CHG_INT_HI) rd_next = chg_int_reg[31:16];
    else if (REQ.cmd == CMD_PEAK_VOLT) rd_next = peak_v_reg;
    else if (REQ.cmd == CMD_TROUGH_VOLT) rd_next = trough_v_reg;
    else if (REQ.cmd == CMD_PEAK_TEMP) rd_next = peak_t_reg;
    else if (REQ.cmd == CMD_TROUGH_TEMP) rd_next = trough_t_reg;
    else if (REQ.cmd == CMD_OWNER_LO) rd_next = owner_reg[15:0];
    else if (REQ.cmd == CMD_OWNER_HI) rd_next = owner_reg[31:16];
    else if (REQ.cmd == CMD_CRC_LO) rd_next = CRC_RESULT[15:0];
    else if (REQ.cmd == CMD_CRC_HI) rd_next = CRC_RESULT[31:16];
  end

  // Registered outputs
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      RDATA <= ZERO16;
      RVALID <= 1'b0;
      PROFILE <= '0;
      ALARM_STATE <= ALARM_STATE_RST;
    end else if (CE) begin
      RVALID <= REQ.rd;
      if (REQ.rd) RDATA <= rd_next;
      PROFILE <= prof_reg;
      ALARM_STATE <= state_next;
    end
  end

  // Checks
  peak_rst_a: assert property (@(posedge CORE_CLK) $fell(RST) |-> peak_v_reg == ZERO16)
    else $error("peak voltage not zero after reset");
  trough_rst_a: assert property (@(posedge CORE_CLK) $fell(RST) |-> trough_v_reg == VOLT_MAX)
    else $error("trough voltage not 5 V after reset");
  peak_temp_a: assert property (@(posedge CORE_CLK) $fell(RST) |-> peak_t_reg == TEMP_MIN)
    else $error("peak temperature reset wrong");
  trough_temp_a: assert property (@(posedge CORE_CLK) $fell(RST) |-> trough_t_reg == TEMP_MAX)
    else $error("trough temperature reset wrong");
  hv_disabled_a: assert property (@(posedge CORE_CLK) disable iff (RST)
    (CE && alm_hv_reg == ZERO16) |-> !hit[0])
    else $error("disabled high voltage alarm fired");
  lv_disabled_a: assert property (@(posedge CORE_CLK) disable iff (RST)
    (CE && alm_lv_reg == ZERO16) |-> !hit[1])
    else $error("disabled low voltage alarm fired");
  ht_flag_a: assert property (@(posedge CORE_CLK) disable iff (RST)
    (CE && hit[2]) |=> state_reg[ALM_HIGH_TEMP])
    else $error("high temperature flag not set");
  lt_flag_a: assert property (@(posedge CORE_CLK) disable iff (RST)
    (CE && hit[3]) |=> state_reg[ALM_LOW_TEMP])
    else $error("low temperature flag not set");
  lc_flag_a: assert property (@(posedge CORE_CLK) disable iff (RST)
    (CE && SAMPLE.valid && alm_lc_reg != ZERO16 && SAMPLE.charge_pct <= alm_lc_reg)
    |=> state_reg[ALM_LOW_CHARGE])
    else $error("low charge flag not set");
  state_rst_a: assert property (@(posedge CORE_CLK) $fell(RST) |-> state_reg == ALARM_STATE_RST)
    else $error("status word reset wrong");
  profile_range_a: assert property (@(posedge CORE_CLK) disable iff (RST)
    prof_reg <= PROFILE_LAST[2:0])
    else $error("profile out of range");
  init_pulse_a: assert property (@(posedge CORE_CLK) disable iff (RST)
    (wr_ok && REQ.cmd == CMD_PROFILE_SEL) |=> INIT_START)
    else $error("initialization not started");
  profile_id_a: assert property (@(posedge CORE_CLK) disable iff (RST)
    (CE && REQ.rd && REQ.cmd == CMD_PROFILE_ID) |=> RVALID && RDATA == PROFILE_ID)
    else $error("profile id read wrong");
  store_load_a: assert property (@(posedge CORE_CLK) disable iff (RST)
    (CE && strap_pend_reg) |=> alm_hv_reg == $past(STORE_ALM_HV))
    else $error("store value not loaded");
  peak_track_a: assert property (@(posedge CORE_CLK) disable iff (RST)
    (CE && SAMPLE.valid && SAMPLE.volt_mv > peak_v_reg) |=> peak_v_reg == $past(SAMPLE.volt_mv))
    else $error("peak voltage not tracked");
  trough_track_a: assert property (@(posedge CORE_CLK) disable iff (RST)
    (CE && SAMPLE.valid && SAMPLE.volt_mv < trough_v_reg) |=> trough_v_reg == $past(SAMPLE.volt_mv))
    else $error("trough voltage not tracked");
  peak_t_track_a: assert property (@(posedge CORE_CLK) disable iff (RST)
    (CE && SAMPLE.valid && SAMPLE.temp_dk > peak_t_reg) |=> peak_t_reg == $past(SAMPLE.temp_dk))
    else $error("peak temperature not tracked");
  trough_t_track_a: assert property (@(posedge CORE_CLK) disable iff (RST)
    (CE && SAMPLE.valid && SAMPLE.temp_dk < trough_t_reg) |=> trough_t_reg == $past(SAMPLE.temp_dk))
    else $error("trough temperature not tracked");
  peak_read_a: assert property (@(posedge CORE_CLK) disable iff (RST)
    (CE && REQ.rd && REQ.cmd == CMD_PEAK_VOLT) |=> RDATA == $past(peak_v_reg))
    else $error("peak voltage read wrong");

  // Profile select steps: a legal code selects, any code pulses the start
  sequence sel_valid_s;
    wr_ok && REQ.cmd == CMD_PROFILE_SEL && REQ.wdata <= PROFILE_LAST;
  endsequence
  sequence sel_bad_s;
    wr_ok && REQ.cmd == CMD_PROFILE_SEL && REQ.wdata > PROFILE_LAST;
  endsequence
  profile_take_a: assert property (@(posedge CORE_CLK) disable iff (RST)
    sel_valid_s |=> prof_reg == $past(REQ.wdata[2:0]))
    else $error("profile code not taken");
  profile_keep_a: assert property (@(posedge CORE_CLK) disable iff (RST)
    sel_bad_s |=> prof_reg == $past(prof_reg))
    else $error("bad profile code selected");
  profile_port_a: assert property (@(posedge CORE_CLK) disable iff (RST)
    CE |=> PROFILE == $past(prof_reg))
    else $error("profile port lags wrong");
  init_bad_a: assert property (@(posedge CORE_CLK) disable iff (RST)
    sel_bad_s |=> INIT_START)
    else $error("no start on bad profile code");
  init_idle_a: assert property (@(posedge CORE_CLK) disable iff (RST)
    (CE && !(wr_ok && REQ.cmd == CMD_PROFILE_SEL)) |=> !INIT_START)
    else $error("spurious initialization start");

  // Alarm flags, host-written levels and status word, status port and owner tag store load
  hv_flag_a: assert property (@(posedge CORE_CLK) disable iff (RST)
    (CE && hit[0]) |=> state_reg[ALM_HIGH_VOLT])
    else $error("high voltage flag not set");
  lv_flag_a: assert property (@(posedge CORE_CLK) disable iff (RST)
    (CE && hit[1]) |=> state_reg[ALM_LOW_VOLT])
    else $error("low voltage flag not set");
  hv_level_a: assert property (@(posedge CORE_CLK) disable iff (RST)
    (wr_ok && !strap_pend_reg && REQ.cmd == CMD_HIGH_VOLT_ALM) |=> alm_hv_reg == $past(REQ.wdata))
    else $error("high voltage level not written");
  lv_level_a: assert property (@(posedge CORE_CLK) disable iff (RST)
    (wr_ok && !strap_pend_reg && REQ.cmd == CMD_LOW_VOLT_ALM) |=> alm_lv_reg == $past(REQ.wdata))
    else $error("low voltage level not written");
  ht_level_a: assert property (@(posedge CORE_CLK) disable iff (RST)
    (wr_ok && !strap_pend_reg && REQ.cmd == CMD_HIGH_TEMP_ALM) |=> alm_ht_reg == $past(REQ.wdata))
    else $error("high temperature level not written");
  lt_level_a: assert property (@(posedge CORE_CLK) disable iff (RST)
    (wr_ok && !strap_pend_reg && REQ.cmd == CMD_LOW_TEMP_ALM) |=> alm_lt_reg == $past(REQ.wdata))
    else $error("low temperature level not written");
  lc_level_a: assert property (@(posedge CORE_CLK) disable iff (RST)
    (wr_ok && !strap_pend_reg && REQ.cmd == CMD_LOW_CHARGE_ALM) |=> alm_lc_reg == $past(REQ.wdata))
    else $error("low charge level not written");
  state_write_a: assert property (@(posedge CORE_CLK) disable iff (RST)
    (wr_ok && REQ.cmd == CMD_ALARM_STATE && hit == 5'h00) |=> state_reg == $past(REQ.wdata))
    else $error("status word not written");
  alarm_port_a: assert property (@(posedge CORE_CLK) disable iff (RST)
    ALARM_STATE == state_reg)
    else $error("status port differs from register");
  owner_load_a: assert property (@(posedge CORE_CLK) disable iff (RST)
    (CE && strap_pend_reg) |=> owner_reg == $past(STORE_OWNER))
    else $error("owner tag not loaded");

  // Housekeeping: tally, read strobe and freeze
  tally_step_a: assert property (@(posedge CORE_CLK) disable iff (RST)
    (CE && CYCLE_TICK) |=> cycles_reg == $past(cycles_reg) + 16'h0001)
    else $error("cycle tally did not step");
  read_idle_a: assert property (@(posedge CORE_CLK) disable iff (RST)
    (CE && !REQ.rd) |=> !RVALID)
    else $error("read valid without a read");
  freeze_a: assert property (@(posedge CORE_CLK) disable iff (RST)
    !CE |=> state_reg == $past(state_reg) && prof_reg == $past(prof_reg))
    else $error("state moved while frozen");
endmodule

/* test/glr_host_model.sv */
// Purpose: Host side of the register bank, issuing command-code reads and writes
// Assumes: One request per call, taken at the next rising clock edge
// Notes: Read answer is captured in the cycle after the taken edge
`timescale 1ns/100ps
module glr_host_model
  import glr_pkg::*;
(
  input wire logic core_clk, // Core clock
  input wire logic rvalid, // Read data valid from the bank
  input wire logic [15:0] rdata, // Read data from the bank
  output glr_req_t req // Access request toward the bank
);
  initial req = '0;
  // A leading edge wait keeps two calls from driving req in one time step
  task automatic wr(input logic [7:0] cmd, input logic [15:0] data);
    @(posedge core_clk);
    #1 req = '{wr: 1'b1, rd: 1'b0, cmd: cmd, wdata: data};
    @(posedge core_clk);
    #1 req = '0;
  endtask
  // Read answer stands one cycle, so it is taken right after the taken edge
  task automatic rd(input logic [7:0] cmd, output logic [15:0] data, output logic ok);
    @(posedge core_clk);
    #1 req = '{wr: 1'b0, rd: 1'b1, cmd: cmd, wdata: 16'h0000};
    @(posedge core_clk);
    #1 req = '0;
    ok = rvalid;
    data = rdata;
  endtask
endmodule

/* test/glr_regs_test.sv */
// Purpose: Self-checking bench for the gauge log, alarm and profile register bank
// Assumes: All host traffic goes through the host model
// Notes: CE is dropped once, so the freeze path is exercised by a write that must not be taken
`timescale 1ns/100ps
module glr_regs_test;
  import glr_pkg::*;
  localparam logic [15:0] VER_ARB = 16'h3C5A; // Arbitrary value
  localparam logic [15:0] PID_ARB = 16'h7E21; // Arbitrary value
  logic core_clk, rst, ce, cycle_tick, rvalid, init_start, ok;
  glr_req_t req;
  glr_sample_t sample;
  logic [15:0] st_hv, st_lv, st_ht, st_lt, st_lc, rdata, alarm_state, v;
  logic [31:0] st_owner, crc;
  logic [2:0] profile;
  logic [7:0] rcmd [23];
  logic [15:0] rexp [23];
  logic [7:0] wcmd [14];
  logic [15:0] wval [14];
  logic [7:0] lvl [5];
  int fail_count = 0;
  int n_compared = 0;

  glr_regs #(.CHIP_VERSION(VER_ARB), .PROFILE_ID(PID_ARB)) i_glr_regs (
    .CORE_CLK(core_clk), .RST(rst), .CE(ce), .REQ(req), .SAMPLE(sample),
    .STORE_ALM_HV(st_hv), .STORE_ALM_LV(st_lv), .STORE_ALM_HT(st_ht), .STORE_ALM_LT(st_lt),
    .STORE_ALM_LC(st_lc), .STORE_OWNER(st_owner), .CRC_RESULT(crc), .CYCLE_TICK(cycle_tick),
    .RDATA(rdata), .RVALID(rvalid), .PROFILE(profile), .INIT_START(init_start), .ALARM_STATE(alarm_state));
  glr_host_model i_glr_host_model (.core_clk(core_clk), .rvalid(rvalid), .rdata(rdata), .req(req));

  // Clock at 200 MHz
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    i_glr_host_model.wr(c, d);
  endtask
  // Read one code; the answer must arrive exactly one cycle later
  task automatic rchk(input logic [7:0] c, input logic [15:0] exp);
    i_glr_host_model.rd(c, v, ok);
    check($sformatf("rvalid %h", c), {15'h0000, ok}, 16'h0001);
    check($sformatf("code %h", c), v, exp);
  endtask
  // One measurement pulse
  task automatic smp(input logic [15:0] mv, input logic [15:0] dk, input logic [15:0] pct);
    @(posedge core_clk);
    #1 sample = '{valid: 1'b1, volt_mv: mv, temp_dk: dk, charge_pct: pct};
    @(posedge core_clk);
    #1 sample.valid = 1'b0;
  endtask
  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Cuts a hang short; the tests need only a few hundred cycles
  initial begin
    #100000;
    fail_count++;
    end_of_test();
  end

  initial begin
    rst = 1'b1;
    ce = 1'b1;
    cycle_tick = 1'b0;
    sample = '0;
    {st_hv, st_lv, st_ht, st_lt, st_lc} = {16'h1000, 16'h0A00, 16'h0D00, 16'h0A00, 16'h000A};
    st_owner = 32'h5EED0C1A;
    crc = 32'h9D3144E7;
    rcmd = '{8'h17, 8'h19, 8'h24, 8'h25, 8'h26, 8'h27, 8'h28, 8'h29, 8'h2A, 8'h2B, 8'h2C, 8'h2D,
             8'h1F, 8'h14, 8'h21, 8'h20, 8'h13, 8'h36, 8'h37, 8'h38, 8'h39, 8'h11, 8'h1A};
    rexp = '{16'h0000, ALARM_STATE_RST, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
             16'h0000, 16'h1388, 16'h0980, 16'h0DCC, st_hv, st_lv, st_ht, st_lt, st_lc,
             st_owner[15:0], st_owner[31:16], crc[15:0], crc[31:16], VER_ARB, PID_ARB};
    wcmd = '{8'h13, 8'h14, 8'h1F, 8'h20, 8'h21, 8'h24, 8'h26, 8'h27, 8'h28, 8'h29, 8'h2A, 8'h2B, 8'h2C, 8'h2D};
    wval = '{16'h0064, 16'h09C4, 16'h1388, 16'h0980, 16'h0DCC, 16'hBEEF, 16'h1357, 16'h2468,
             16'h0ACE, 16'h0BDF, 16'h1200, 16'h0A00, 16'h0D00, 16'h0A00};
    lvl = '{CMD_LOW_CHARGE_ALM, CMD_LOW_VOLT_ALM, CMD_HIGH_VOLT_ALM, CMD_LOW_TEMP_ALM, CMD_HIGH_TEMP_ALM};
    repeat (6) @(posedge core_clk);
    #1 check("alarm port", alarm_state, ALARM_STATE_RST);
    rst = 1'b0;
    // Store load happens in the first cycle after release
    repeat (2) @(posedge core_clk);
    for (int i = 0; i < 23; i++) rchk(rcmd[i], rexp[i]);
    // History tracking and alarms; low temperature hits its level exactly
    smp(16'h0FA0, 16'h0BA6, 16'h0032);
    smp(16'h1100, 16'h0A00, 16'h0005);
    rchk(CMD_PEAK_VOLT, 16'h1100);
    rchk(CMD_TROUGH_VOLT, 16'h0FA0);
    rchk(CMD_PEAK_TEMP, 16'h0BA6);
    rchk(CMD_TROUGH_TEMP, 16'h0A00);
    v = ALARM_STATE_RST | (16'h0001 << ALM_HIGH_VOLT) | (16'h0001 << ALM_LOW_TEMP) | (16'h0001 << ALM_LOW_CHARGE);
    rchk(CMD_ALARM_STATE, v);
    check("alarm port", alarm_state, v);
    // Zero levels disable every alarm, even at the range ends
    for (int i = 0; i < 5; i++) wr(lvl[i], 16'h0000);
    wr(CMD_ALARM_STATE, ALARM_STATE_RST);
    smp(16'h1388, 16'h0980, 16'h0001);
    smp(16'h09C4, 16'h0DCC, 16'h0064);
    rchk(CMD_ALARM_STATE, ALARM_STATE_RST);
    // Writable registers read back what was written; the runtime high half keeps only its low byte
    for (int i = 0; i < 14; i++) wr(wcmd[i], wval[i]);
    for (int i = 0; i < 14; i++) rchk(wcmd[i], wval[i]);
    wr(CMD_RUNTIME_HI, 16'hABCD);
    rchk(CMD_RUNTIME_HI, 16'h00CD);
    wr(CMD_ALARM_STATE, 16'h1234);
    rchk(CMD_ALARM_STATE, 16'h1234);
    // Clock enable low freezes the bank, so a write is not taken
    ce = 1'b0;
    wr(CMD_ALARM_STATE, 16'hFFFF);
    ce = 1'b1;
    rchk(CMD_ALARM_STATE, 16'h1234);
    // Every profile code, then an out-of-range code that must not select
    for (int p = 0; p < 6; p++) begin
      wr(CMD_PROFILE_SEL, 16'(p));
      check("init pulse", {15'h0000, init_start}, 16'h0001);
      @(posedge core_clk);
      #1 check("profile", {13'h0000, profile}, (p < 5) ? 16'(p) : PROFILE_LAST);
      check("init end", {15'h0000, init_start}, 16'h0000);
    end
    repeat (3) begin
      @(posedge core_clk);
      #1 cycle_tick = 1'b1;
      @(posedge core_clk);
      #1 cycle_tick = 1'b0;
    end
    rchk(CMD_CYCLE_TALLY, 16'h0003);
    // Read-only codes ignore writes
    wr(CMD_CHIP_VERSION, 16'hFFFF);
    wr(CMD_PROFILE_ID, 16'hFFFF);
    rchk(CMD_CHIP_VERSION, VER_ARB);
    rchk(CMD_PROFILE_ID, PID_ARB);
    // The host keeps to defined codes only; last check uses the top code
    rchk(CMD_CRC_HI, crc[31:16]);
    end_of_test();
  end
endmodule
